// *** src/psir_top.sv ***
// status, interrupt enable and status change registers of a 10/100 phy, wishbone slave
// What this block does
// - speed bit one in 100 mbps mode
// - transmit bit follows packet transmission
// - receive bit follows packet reception
// - collision, link, duplex shown as live bits
// - negotiation mode bit one when autonegotiating
// - completion bit mirrors basic status completion
// - polarity bit one when polarity reversed
// - pause bit one when pause capable
// - error bit set on any fault
// - error bit held until source registers read
// - negotiation done interrupts only when masked in
// - speed change interrupts only when masked in
// - duplex change interrupts only when masked in
// - link change interrupts only when masked in
// - global enable zero blocks every change interrupt; the test bit still drives the pin
// - test bit forces interrupt pin active
// - negotiation done flag set, cleared on read
// - speed change flag held until read
// - duplex change flag held until read
// - link change flag held until read
// - pending bit shows outstanding interrupt
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "psir_defines.svh"

module psir_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // live state from the transceiver core
  input  wire logic        speed_100_i,
  input  wire logic        tx_active_i,
  input  wire logic        rx_active_i,
  input  wire logic        collision_i,
  input  wire logic        link_up_i,
  input  wire logic        full_duplex_i,
  input  wire logic        autoneg_mode_i,
  input  wire logic        autoneg_complete_i,
  input  wire logic        polarity_rev_i,
  input  wire logic        pause_capable_i,
  // fault sources and the read that clears them
  input  wire logic        remote_fault_i,
  input  wire logic        jabber_i,
  input  wire logic        parallel_fault_i,
  input  wire logic        error_src_read_i,
  // management interrupt pin
  output logic             mgmt_irq_n_o
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  psir_pkg::psir_sel_t sel;
  logic                take;
  logic                take_rd;
  logic                take_wr;
  logic                wr_low;
  logic                ack;

  // ack low is part of the take so each request is answered once;
  // a master that holds on past its ack is simply taken again
  assign take    = wb_cyc_i & wb_stb_i & ~ack;
  assign take_rd = take & ~wb_we_i;
  assign take_wr = take & wb_we_i;
  // every meaningful enable bit sits in byte lane 0
  assign wr_low  = take_wr & wb_sel_i[0];

  assign sel = (wb_adr_i[7:2] == `PSIR_IDX_LIVE) ? psir_pkg::PSIR_SEL_LIVE :
               (wb_adr_i[7:2] == `PSIR_IDX_IEN)  ? psir_pkg::PSIR_SEL_IEN  :
               (wb_adr_i[7:2] == `PSIR_IDX_CHG)  ? psir_pkg::PSIR_SEL_CHG  :
                                                   psir_pkg::PSIR_SEL_NONE;

  // ---------------------------------------------------------------
  // ack: one cycle after the request, dropped the cycle after
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack <= 1'b0;
    else
      ack <= take;
  end

  assign wb_ack_o = ack;

  // ---------------------------------------------------------------
  // interrupt enable word
  // ---------------------------------------------------------------
  logic             negotiation_done_mask;
  logic             rate_change_mask;
  logic             duplex_change_mask;
  logic             link_change_mask;
  logic             global_irq_enable;
  logic             test_force_irq;
  logic             ien_wr;
  logic             next_negotiation_done_mask;
  logic             next_rate_change_mask;
  logic             next_duplex_change_mask;
  logic             next_link_change_mask;
  logic             next_global_irq_enable;
  logic             next_test_force_irq;

  assign ien_wr = wr_low & (sel == psir_pkg::PSIR_SEL_IEN);

  // a write without byte lane 0 leaves every enable bit as it was
  assign next_negotiation_done_mask = ien_wr ? wb_dat_i[`PSIR_IEN_NEG] :
                                               negotiation_done_mask;
  assign next_rate_change_mask      = ien_wr ? wb_dat_i[`PSIR_IEN_RATE] :
                                               rate_change_mask;
  assign next_duplex_change_mask    = ien_wr ? wb_dat_i[`PSIR_IEN_DUPLEX] :
                                               duplex_change_mask;
  assign next_link_change_mask      = ien_wr ? wb_dat_i[`PSIR_IEN_LINK] :
                                               link_change_mask;
  assign next_global_irq_enable     = ien_wr ? wb_dat_i[`PSIR_IEN_GIE] :
                                               global_irq_enable;
  assign next_test_force_irq        = ien_wr ? wb_dat_i[`PSIR_IEN_TEST] :
                                               test_force_irq;

  // reserved bits are not stored; the host writes them as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      negotiation_done_mask <= 1'b0;
      rate_change_mask      <= 1'b0;
      duplex_change_mask    <= 1'b0;
      link_change_mask      <= 1'b0;
      global_irq_enable     <= 1'b0;
      test_force_irq        <= 1'b0;
    end
    else
    begin
      negotiation_done_mask <= next_negotiation_done_mask;
      rate_change_mask      <= next_rate_change_mask;
      duplex_change_mask    <= next_duplex_change_mask;
      link_change_mask      <= next_link_change_mask;
      global_irq_enable     <= next_global_irq_enable;
      test_force_irq        <= next_test_force_irq;
    end
  end

  // ---------------------------------------------------------------
  // change flags, cleared by a read of the status change word
  // ---------------------------------------------------------------
  logic                chg_rd;
  logic                fault_any;
  logic                err_flag;
  psir_pkg::psir_evt_t flags;
  psir_pkg::psir_evt_t masks;
  psir_pkg::psir_evt_t armed;

  // a read with any byte lanes clears the flags; reads ignore wb_sel_i
  assign chg_rd    = take_rd & (sel == psir_pkg::PSIR_SEL_CHG);
  assign fault_any = remote_fault_i | jabber_i | parallel_fault_i;

  // completion is an edge; a flag already set stays set until read
  psir_event #(
    .RISE_ONLY (1'b1),
    .LEVEL_SET (1'b0)
  ) u_neg_done (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (autoneg_complete_i),
    .clear_i   (chg_rd),
    .flag_o    (flags.neg)
  );

  psir_event #(
    .RISE_ONLY (1'b0),
    .LEVEL_SET (1'b0)
  ) u_rate_chg (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (speed_100_i),
    .clear_i   (chg_rd),
    .flag_o    (flags.rate)
  );

  psir_event #(
    .RISE_ONLY (1'b0),
    .LEVEL_SET (1'b0)
  ) u_duplex_chg (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (full_duplex_i),
    .clear_i   (chg_rd),
    .flag_o    (flags.duplex)
  );

  psir_event #(
    .RISE_ONLY (1'b0),
    .LEVEL_SET (1'b0)
  ) u_link_chg (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (link_up_i),
    .clear_i   (chg_rd),
    .flag_o    (flags.link)
  );

  // a fault still present keeps the error set across the clearing read
  psir_event #(
    .RISE_ONLY (1'b0),
    .LEVEL_SET (1'b1)
  ) u_error (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .level_i   (fault_any),
    .clear_i   (error_src_read_i),
    .flag_o    (err_flag)
  );

  // ---------------------------------------------------------------
  // interrupt generation
  // ---------------------------------------------------------------
  logic irq_any;
  logic irq_from_events;
  logic irq_pending;
  logic mgmt_irq_n;
  logic negotiation_done_flag;
  logic rate_change_flag;
  logic duplex_change_flag;
  logic link_change_flag;

  // named views of the sticky flags, as software sees them
  assign negotiation_done_flag = flags.neg;
  assign rate_change_flag      = flags.rate;
  assign duplex_change_flag    = flags.duplex;
  assign link_change_flag      = flags.link;

  assign masks.neg       = negotiation_done_mask;
  assign masks.rate      = rate_change_mask;
  assign masks.duplex    = duplex_change_mask;
  assign masks.link      = link_change_mask;
  assign armed           = flags & masks;
  assign irq_any         = |armed;
  assign irq_from_events = global_irq_enable & irq_any;
  // test force overrides the global enable
  assign irq_pending     = test_force_irq | irq_from_events;

  // pin follows the pending level one cycle late, glitch free;
  // software polling the pending bit sees it in the same cycle as the pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mgmt_irq_n <= 1'b1;
    else
      mgmt_irq_n <= ~irq_pending;
  end

  assign mgmt_irq_n_o = mgmt_irq_n;

  // ---------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------
  logic [15:0] live_word;
  logic [15:0] ien_word;
  logic [15:0] chg_word;

  // reserved bits read as zero
  // the error bit is the only stored bit here, the rest are live
  always_comb
  begin
    live_word                    = `PSIR_WORD_RST;
    live_word[`PSIR_LIVE_SPEED]  = speed_100_i;
    live_word[`PSIR_LIVE_TX]     = tx_active_i;
    live_word[`PSIR_LIVE_RX]     = rx_active_i;
    live_word[`PSIR_LIVE_COL]    = collision_i;
    live_word[`PSIR_LIVE_LINK]   = link_up_i;
    live_word[`PSIR_LIVE_DUPLEX] = full_duplex_i;
    live_word[`PSIR_LIVE_ANMODE] = autoneg_mode_i;
    live_word[`PSIR_LIVE_ANCOMP] = autoneg_complete_i;
    // not meaningful at 100 mbps; passed through raw
    live_word[`PSIR_LIVE_POL]    = polarity_rev_i;
    live_word[`PSIR_LIVE_PAUSE]  = pause_capable_i;
    live_word[`PSIR_LIVE_ERR]    = err_flag;
  end

  always_comb
  begin
    ien_word                     = `PSIR_WORD_RST;
    ien_word[`PSIR_IEN_NEG]      = negotiation_done_mask;
    ien_word[`PSIR_IEN_RATE]     = rate_change_mask;
    ien_word[`PSIR_IEN_DUPLEX]   = duplex_change_mask;
    ien_word[`PSIR_IEN_LINK]     = link_change_mask;
    ien_word[`PSIR_IEN_GIE]      = global_irq_enable;
    ien_word[`PSIR_IEN_TEST]     = test_force_irq;
  end

  always_comb
  begin
    chg_word                     = `PSIR_WORD_RST;
    chg_word[`PSIR_CHG_NEG]      = negotiation_done_flag;
    chg_word[`PSIR_CHG_RATE]     = rate_change_flag;
    chg_word[`PSIR_CHG_DUPLEX]   = duplex_change_flag;
    chg_word[`PSIR_CHG_LINK]     = link_change_flag;
    chg_word[`PSIR_CHG_PEND]     = irq_pending;
  end

  // ---------------------------------------------------------------
  // read data register
  // ---------------------------------------------------------------
  logic [15:0] sel_word;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  always_comb
  begin
    sel_word = `PSIR_WORD_RST;
    unique case (sel)
      psir_pkg::PSIR_SEL_LIVE: sel_word = live_word;
      psir_pkg::PSIR_SEL_IEN:  sel_word = ien_word;
      psir_pkg::PSIR_SEL_CHG:  sel_word = chg_word;
      psir_pkg::PSIR_SEL_NONE: sel_word = `PSIR_WORD_RST;
    endcase
  end

  // flags are captured before the clear of the same edge takes them
  // write cycles load zero so old read data never lingers on the bus
  assign next_rdata = take_rd ? {`PSIR_UPPER_ZERO, sel_word} : `PSIR_BUS_RST;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata <= `PSIR_BUS_RST;
    else if (take)
      rdata <= next_rdata;
  end

  assign wb_dat_o = rdata;

endmodule : psir_top

// *** src/psir_defines.svh ***
// register indices, field positions and reset values of the phy status/interrupt block
`ifndef PSIR_DEFINES_SVH
`define PSIR_DEFINES_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define PSIR_IDX_LIVE      6'h11
`define PSIR_IDX_IEN       6'h12
`define PSIR_IDX_CHG       6'h13

// ---------------------------------------------------------------
// live status word fields
// ---------------------------------------------------------------
`define PSIR_LIVE_SPEED    14
`define PSIR_LIVE_TX       13
`define PSIR_LIVE_RX       12
`define PSIR_LIVE_COL      11
`define PSIR_LIVE_LINK     10
`define PSIR_LIVE_DUPLEX   9
`define PSIR_LIVE_ANMODE   8
`define PSIR_LIVE_ANCOMP   7
`define PSIR_LIVE_POL      5
`define PSIR_LIVE_PAUSE    4
`define PSIR_LIVE_ERR      3

// ---------------------------------------------------------------
// interrupt enable word fields
// ---------------------------------------------------------------
`define PSIR_IEN_NEG       7
`define PSIR_IEN_RATE      6
`define PSIR_IEN_DUPLEX    5
`define PSIR_IEN_LINK      4
`define PSIR_IEN_GIE       1
`define PSIR_IEN_TEST      0

// ---------------------------------------------------------------
// status change word fields
// ---------------------------------------------------------------
`define PSIR_CHG_NEG       7
`define PSIR_CHG_RATE      6
`define PSIR_CHG_DUPLEX    5
`define PSIR_CHG_LINK      4
`define PSIR_CHG_PEND      2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PSIR_WORD_RST      16'h0000
`define PSIR_BUS_RST       32'h0000_0000
`define PSIR_UPPER_ZERO    16'h0000

`endif

// *** src/psir_pkg.sv ***
// types shared by the phy status/interrupt block
package psir_pkg;

  // ---------------------------------------------------------------
  // register select
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PSIR_SEL_NONE,
    PSIR_SEL_LIVE,
    PSIR_SEL_IEN,
    PSIR_SEL_CHG
  } psir_sel_t;

  // ---------------------------------------------------------------
  // one bit per change event
  // ---------------------------------------------------------------
  typedef struct packed {
    logic neg;
    logic rate;
    logic duplex;
    logic link;
  } psir_evt_t;

endpackage : psir_pkg

// *** src/psir_event.sv ***
// sticky event flag with change, rise or level detection and set-over-clear
`timescale 1ns/1ps

module psir_event #(
  parameter bit RISE_ONLY = 1'b0,
  parameter bit LEVEL_SET = 1'b0
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // event source and clear strobe
  input  wire logic level_i,
  input  wire logic clear_i,
  // sticky flag
  output logic      flag_o
);

  logic prev;
  logic flag;
  logic seen;
  logic next_flag;

  // ---------------------------------------------------------------
  // detection
  // ---------------------------------------------------------------
  assign seen      = LEVEL_SET ? level_i :
                     (RISE_ONLY ? (level_i & ~prev) : (level_i ^ prev));
  // a set in the clearing cycle wins so no event is lost
  assign next_flag = seen | (flag & ~clear_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev <= 1'b0;
      flag <= 1'b0;
    end
    else
    begin
      prev <= level_i;
      flag <= next_flag;
    end
  end

  assign flag_o = flag;

endmodule : psir_event

// *** tb/psir_assertions.sv ***
// checker of the status/interrupt block's bus answers and interrupt pin
`timescale 1ns/1ps
module psir_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // live state and faults
  input wire logic        speed_100_i,
  input wire logic        link_up_i,
  input wire logic        full_duplex_i,
  input wire logic        remote_fault_i,
  input wire logic        jabber_i,
  input wire logic        parallel_fault_i,
  // interrupt pin
  input wire logic        mgmt_irq_n_o
);
  // ---------------------------------------------------------------
  // decode of taken requests
  // ---------------------------------------------------------------
  wire logic       tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic [5:0] idx = wb_adr_i[7:2];
  wire logic       rd_live = tk & ~wb_we_i & (idx == 6'h11);
  wire logic       rd_chg = tk & ~wb_we_i & (idx == 6'h13);
  wire logic       rd_none = tk & ~wb_we_i & ((idx < 6'h11) | (idx > 6'h13));
  wire logic       fault = remote_fault_i | jabber_i | parallel_fault_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_ack_after_take: assert property (tk |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(tk))
    else $error("ack without a request");
  a_upper_half_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_live_bits: assert property (rd_live |=> wb_dat_o[14] == $past(speed_100_i)
    && wb_dat_o[10] == $past(link_up_i) && wb_dat_o[9] == $past(full_duplex_i))
    else $error("live word bits differ from inputs");
  a_error_sticky: assert property (rd_live && $past(fault) && !$past(rst_i) |=> wb_dat_o[3])
    else $error("error bit missing after a fault");
  a_pend_pin: assert property (wb_ack_o && $past(rd_chg) |-> wb_dat_o[2] == !mgmt_irq_n_o)
    else $error("pending bit and pin disagree");
  a_unmapped_zero: assert property (rd_none |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0) $past(rst_i) |-> mgmt_irq_n_o && !wb_ack_o)
    else $error("pin or ack active after reset");

  c_pin_low: cover property ($fell(mgmt_irq_n_o));
  c_chg_read: cover property (rd_chg);
  c_fault_read: cover property (rd_live && $past(fault));
endmodule : psir_checker

bind psir_top psir_checker u_chk (.*);

// *** tb/psir_host.sv ***
// management host model: classic wishbone master for the register bus
`timescale 1ns/1ps
module psir_host (
  // clock
  input  wire logic        clk_i,
  // slave answer
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  // byte lanes of the next transfer; the bench may drop lanes
  logic [3:0] sel_next;

  initial
  begin
    {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
    sel_next = 4'hF;
  end

  // one transfer; released address and data lines show inverted values so stale data is never trusted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    int n;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= sel_next;
    dat_o <= d;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = (ack_i === 1'b1);
    end
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : xfer
endmodule : psir_host

// *** tb/testbench.sv ***
// self-checking bench of the phy status/interrupt registers
`timescale 1ns/1ps
module testbench;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mgmt_irq_n_o, err_rd;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [9:0]  live;
  logic [2:0]  fault;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          ev [4] = '{5, 4, 9, 2};
  typedef struct {logic [9:0] in; logic [15:0] exp;} psir_row_t;
  psir_row_t   rows [4] = '{'{10'h3FF, 16'h7FB0}, '{10'h2AA, 16'h5520},
                            '{10'h155, 16'h2A90}, '{10'h000, 16'h0000}};

  psir_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .speed_100_i(live[9]), .tx_active_i(live[8]),
    .rx_active_i(live[7]), .collision_i(live[6]), .link_up_i(live[5]),
    .full_duplex_i(live[4]), .autoneg_mode_i(live[3]), .autoneg_complete_i(live[2]),
    .polarity_rev_i(live[1]), .pause_capable_i(live[0]), .remote_fault_i(fault[0]),
    .jabber_i(fault[1]), .parallel_fault_i(fault[2]), .error_src_read_i(err_rd),
    .mgmt_irq_n_o(mgmt_irq_n_o));
  psir_host host (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== {16'h0000, e})
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    bit ok;
    host.xfer(w, a, {16'h0000, d}, q, ok);
    if (!ok)
    begin
      bad_count++;
      $display("ERROR bus_ack expected 1 seen 0");
      report_and_stop();
    end
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [31:0] q;
    acc(1'b0, a, 16'h0000, q);
    chk(nm, e, q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr

  // toggle a live input and restore it: two changes, or one rise for completion
  task automatic blip(input int b);
    live[b] <= ~live[b];
    @(posedge clk_i);
    live[b] <= ~live[b];
    repeat (4) @(posedge clk_i);
  endtask : blip

  initial
  begin
    rst_i = 1'b1;
    live = '0;
    fault = '0;
    err_rd = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h44, 16'h0000, "live_reset");
    rd(8'h48, 16'h0000, "ien_reset");
    rd(8'h4C, 16'h0000, "chg_reset");
    $display("test reset done");
    foreach (rows[i])
    begin
      live <= rows[i].in;
      @(posedge clk_i);
      rd(8'h44, rows[i].exp, "live_word");
    end
    rd(8'h4C, 16'h00F0, "chg_flags");
    rd(8'h4C, 16'h0000, "chg_cleared");
    $display("test live table done");
    wr(8'h44, 16'hFFFF);
    rd(8'h44, 16'h0000, "live_no_write");
    rd(8'h50, 16'h0000, "unmapped");
    wr(8'h48, 16'h00F3);
    rd(8'h48, 16'h00F3, "ien_rw");
    for (int i = 0; i < 4; i++)
      for (int m = 0; m < 2; m++)
      begin
        wr(8'h48, 16'h0002 | (m ? (16'h0010 << i) : (16'h00F0 & ~(16'h0010 << i))));
        blip(ev[i]);
        chk("irq_pin", m ? 16'h0000 : 16'h0001, {31'h0, mgmt_irq_n_o});
        rd(8'h4C, (16'h0010 << i) | (m ? 16'h0004 : 16'h0000), "chg_event");
        @(posedge clk_i);
        chk("irq_release", 16'h0001, {31'h0, mgmt_irq_n_o});
      end
    $display("test masks done");
    wr(8'h48, 16'h00F0);
    blip(5);
    chk("irq_no_gie", 16'h0001, {31'h0, mgmt_irq_n_o});
    rd(8'h4C, 16'h0010, "chg_no_gie");
    wr(8'h48, 16'h0001);
    repeat (3) @(posedge clk_i);
    chk("irq_test", 16'h0000, {31'h0, mgmt_irq_n_o});
    rd(8'h4C, 16'h0004, "chg_test");
    wr(8'h48, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk("irq_test_off", 16'h0001, {31'h0, mgmt_irq_n_o});
    host.sel_next = 4'hE;
    wr(8'h48, 16'h00F2);
    host.sel_next = 4'hF;
    rd(8'h48, 16'h0000, "ien_lane_off");
    $display("test enable and force done");
    for (int k = 0; k < 3; k++)
    begin
      fault <= 3'b001 << k;
      @(posedge clk_i);
      fault <= 3'b000;
      rd(8'h44, 16'h0008, "err_set");
      rd(8'h44, 16'h0008, "err_held");
      err_rd <= 1'b1;
      @(posedge clk_i);
      err_rd <= 1'b0;
      @(posedge clk_i);
      rd(8'h44, 16'h0000, "err_clear");
    end
    $display("test error done");
    wr(8'h48, 16'h0001);
    live[5] <= ~live[5];
    rd(8'h4C, 16'h0004, "chg_same_cycle");
    rd(8'h4C, 16'h0014, "chg_set_wins");
    $display("test set wins done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("irq_in_reset", 16'h0001, {31'h0, mgmt_irq_n_o});
    chk("dat_in_reset", 16'h0000, wb_dat_o);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h48, 16'h0000, "ien_after_reset");
    rd(8'h4C, 16'h0010, "chg_after_reset");
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : testbench
